/* File: pkg/tcs_defs.vh */
`ifndef TCS_DEFS_VH
`define TCS_DEFS_VH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define TCS_IDX_W 10
`define TCS_IDX_CNT_LO 10'h0A4
`define TCS_IDX_CNT_HI 10'h0A5
`define TCS_IDX_STAT 10'h0A6
`define TCS_IDX_CTRL 10'h0AC

// ----------------------------------------------------------------
// event status / mask register fields
// ----------------------------------------------------------------
`define TCS_STAT_EDGE 7
`define TCS_STAT_LO_CY 6
`define TCS_STAT_HI_CY 5
`define TCS_STAT_MEAS 4
`define TCS_MASK_EDGE 3
`define TCS_MASK_LO_CY 2
`define TCS_MASK_HI_CY 1
`define TCS_MASK_MEAS 0

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define TCS_CTRL_SEL_LSB 0
`define TCS_CTRL_SEL_MSB 2
`define TCS_CTRL_INVERT 3
`define TCS_CTRL_ENABLE 4
`define TCS_CTRL_HI_OSC 5
`define TCS_CTRL_LEVEL 7

// ----------------------------------------------------------------
// edge source select codes
// ----------------------------------------------------------------
`define TCS_SRC_CMP0 3'h0
`define TCS_SRC_LS_OSC 3'h1
`define TCS_SRC_CMP1 3'h2
`define TCS_SRC_OSC_TC 3'h3
`define TCS_SRC_INTERVAL 3'h4
`define TCS_SRC_OSC_IRQ 3'h5
`define TCS_SRC_ABUS 3'h6
`define TCS_SRC_ZERO 3'h7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TCS_RST_COUNT 8'h00
`define TCS_RST_STAT 8'h00
`define TCS_RST_CTRL 8'h00
`define TCS_RST_SEL 3'h0
`define TCS_BYTE_MAX 8'hFF

`endif

/* File: rtl/tcs_byte_counter.v */
`include "tcs_defs.vh"

module tcs_byte_counter #(
    parameter WIDTH = 8
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire clear_i,
    input wire inc_i,
    output wire [WIDTH-1:0] count_o,
    output wire carry_o
);

    reg [WIDTH-1:0] count_q;
    reg [WIDTH-1:0] count_d;

    // carry is taken on the wrap, same cycle as the increment
    assign carry_o = inc_i & ~clear_i & (&count_q);
    assign count_o = count_q;

    always @* begin
        count_d = count_q;
        if (clear_i) begin
            count_d = {WIDTH{1'b0}};
        end else if (inc_i) begin
            count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_q <= {WIDTH{1'b0}};
        end else begin
            count_q <= count_d;
        end
    end

endmodule // tcs_byte_counter

/* File: rtl/tcs_counter_status.v */
// Behaviour
// - low count register reads low byte
// - high count register reads high byte
// - disabled counter forces both bytes zero
// - rising edge on selected input sets bit7, a falling edge when inverted
// - low byte carry sets bit 6
// - high byte carry sets bit 5
// - measurement done sets bit 4
// - writing zero clears flag, one keeps
// - mask bit 3 gates edge flag
// - mask bit 2 gates low carry
// - mask bit 1 gates high carry
// - mask bit 0 gates measurement done
// - three-bit selector picks edge source

`include "tcs_defs.vh"

module tcs_counter_status (
    input wire core_clk_i,
    input wire rst_i,
    // wishbone classic slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [11:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    // counter timing from the core
    input wire run_i,
    input wire low_tick_i,
    input wire osc_tick_i,
    input wire meas_done_i,
    // candidate edge sources
    input wire cmp0_i,
    input wire low_speed_osc_i,
    input wire cmp1_i,
    input wire relaxation_osc_tc_i,
    input wire interval_timer_i,
    input wire relaxation_osc_irq_i,
    input wire analog_bus_i,
    // outputs
    output wire counter_enable_o,
    output wire irq_o
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    reg ack_q;
    reg [31:0] rdata_q;
    reg [31:0] rdata_d;
    reg [3:0] flag_q;
    reg [3:0] flag_d;
    reg [3:0] mask_q;
    reg [3:0] mask_d;
    reg [2:0] edge_source_select_q;
    reg invert_q;
    reg enable_q;
    reg hi_on_osc_q;
    reg sel_level_q;
    reg irq_q;
    reg irq_d;
    reg sel_raw;
    wire sel_level;
    wire [`TCS_IDX_W-1:0] adr_idx;
    wire bus_req;
    wire wr_strobe;
    wire bus_rd;
    wire lane0_wr;
    wire hit_stat;
    wire hit_ctrl;
    wire stat_wr;
    wire ctrl_wr;
    wire [7:0] wdat;
    wire [7:0] cnt_lo;
    wire [7:0] cnt_hi;
    wire lo_carry;
    wire hi_carry;
    wire lo_inc;
    wire hi_inc;
    wire cnt_clear;
    wire edge_event;
    wire [3:0] flag_set;
    wire [3:0] flag_wclr;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    assign adr_idx = wb_adr_i[11:2];
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign bus_rd = bus_req & ~wb_we_i;
    assign hit_stat = (adr_idx == `TCS_IDX_STAT);
    assign hit_ctrl = (adr_idx == `TCS_IDX_CTRL);
    assign wdat = wb_dat_i[7:0];

    // ----------------------------------------------------------------
    // write strobes
    // ----------------------------------------------------------------
    // a write lands on the edge that also samples ack high, while the
    // master still holds address and data, so register and answer
    // agree on one edge; this costs nothing as ack is registered anyway
    assign wr_strobe = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
    // all registers are one byte wide, only lane 0 carries data
    // with sel[0] low the whole write is dropped
    assign lane0_wr = wr_strobe & wb_sel_i[0];
    assign stat_wr = lane0_wr & hit_stat;
    assign ctrl_wr = lane0_wr & hit_ctrl;

    // ----------------------------------------------------------------
    // bus answer
    // ----------------------------------------------------------------
    // one wait state: ack is registered, dropped the cycle after
    // a new request is only taken once ack has dropped
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req;
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always @* begin
        rdata_d = 32'h0000_0000;
        case (adr_idx)
            // the count bytes have no write path at all
            // low byte readout
            `TCS_IDX_CNT_LO: begin
                rdata_d[7:0] = cnt_lo;
            end
            `TCS_IDX_CNT_HI: begin
                rdata_d[7:0] = cnt_hi;
            end
            // flags in the top nibble, masks below
            `TCS_IDX_STAT: begin
                rdata_d[7:0] = {flag_q, mask_q};
            end
            // bit 7 is the sampled level, writes never reach it
            `TCS_IDX_CTRL: begin
                rdata_d[`TCS_CTRL_SEL_MSB:`TCS_CTRL_SEL_LSB] =
                    edge_source_select_q;
                rdata_d[`TCS_CTRL_INVERT] = invert_q;
                rdata_d[`TCS_CTRL_ENABLE] = enable_q;
                rdata_d[`TCS_CTRL_HI_OSC] = hi_on_osc_q;
                rdata_d[`TCS_CTRL_LEVEL] = sel_level_q;
            end
            default: begin
                // unmapped reads answer zero, writes are dropped
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    // data only changes on a read answer, else it holds zero
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (bus_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            edge_source_select_q <= `TCS_RST_SEL;
            invert_q <= 1'b0;
            enable_q <= 1'b0;
            hi_on_osc_q <= 1'b0;
        end else if (ctrl_wr) begin
            edge_source_select_q <=
                wdat[`TCS_CTRL_SEL_MSB:`TCS_CTRL_SEL_LSB];
            invert_q <= wdat[`TCS_CTRL_INVERT];
            enable_q <= wdat[`TCS_CTRL_ENABLE];
            hi_on_osc_q <= wdat[`TCS_CTRL_HI_OSC];
        end
    end

    assign counter_enable_o = enable_q;

    // ----------------------------------------------------------------
    // count bytes
    // ----------------------------------------------------------------
    // disable clears counts
    // counts are only coherent once the core has stopped them,
    // a read while running may catch a byte in mid-carry
    assign cnt_clear = ~enable_q;
    assign lo_inc = enable_q & run_i & low_tick_i;
    // high byte chains from the low carry unless it runs on the osc
    assign hi_inc = enable_q & run_i &
        (hi_on_osc_q ? osc_tick_i : lo_carry);

    tcs_byte_counter #(
        .WIDTH(8)
    ) u_cnt_lo (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .clear_i(cnt_clear),
        .inc_i(lo_inc),
        .count_o(cnt_lo),
        .carry_o(lo_carry)
    );

    tcs_byte_counter #(
        .WIDTH(8)
    ) u_cnt_hi (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .clear_i(cnt_clear),
        .inc_i(hi_inc),
        .count_o(cnt_hi),
        .carry_o(hi_carry)
    );

    // ----------------------------------------------------------------
    // edge source selection
    // ----------------------------------------------------------------
    // source multiplexer
    // code 7 parks the detector on a constant level, low unless the invert bit is set
    always @* begin
        case (edge_source_select_q)
            `TCS_SRC_CMP0: sel_raw = cmp0_i;
            `TCS_SRC_LS_OSC: sel_raw = low_speed_osc_i;
            `TCS_SRC_CMP1: sel_raw = cmp1_i;
            `TCS_SRC_OSC_TC: sel_raw = relaxation_osc_tc_i;
            `TCS_SRC_INTERVAL: sel_raw = interval_timer_i;
            `TCS_SRC_OSC_IRQ: sel_raw = relaxation_osc_irq_i;
            `TCS_SRC_ABUS: sel_raw = analog_bus_i;
            `TCS_SRC_ZERO: sel_raw = 1'b0;
            default: sel_raw = 1'b0;
        endcase
    end

    assign sel_level = sel_raw ^ invert_q;

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_level_q <= 1'b0;
        end else begin
            sel_level_q <= sel_level;
        end
    end

    // rising edge detect
    // a source switch may itself look like an edge
    assign edge_event = sel_level & ~sel_level_q;

    // ----------------------------------------------------------------
    // sticky event flags
    // ----------------------------------------------------------------
    // low carry event
    assign flag_set[2] = lo_carry;
    assign flag_set[1] = hi_carry;
    assign flag_set[0] = meas_done_i;
    // input edge event
    // edges and measurements set even while the counter is off
    assign flag_set[3] = edge_event;

    // zero clears flag
    // the write only clears, it never sets a flag
    assign flag_wclr = stat_wr ? ~wdat[7:4] : 4'h0;

    always @* begin
        // new events win over a clear in the same cycle
        flag_d = (flag_q & ~flag_wclr) | flag_set;
        // the same write always loads the mask nibble
        mask_d = mask_q;
        if (stat_wr) begin
            mask_d = wdat[3:0];
        end
    end

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            flag_q <= 4'h0;
            mask_q <= 4'h0;
        end else begin
            flag_q <= flag_d;
            mask_q <= mask_d;
        end
    end

    // ----------------------------------------------------------------
    // interrupt
    // ----------------------------------------------------------------
    always @* begin
        irq_d = 1'b0;
        // no priority: any unmasked flag raises the line
        // edge flag gate
        if (flag_q[3] && mask_q[`TCS_MASK_EDGE]) begin
            irq_d = 1'b1;
        end
        if (flag_q[2] && mask_q[`TCS_MASK_LO_CY]) begin
            irq_d = 1'b1;
        end
        if (flag_q[1] && mask_q[`TCS_MASK_HI_CY]) begin
            irq_d = 1'b1;
        end
        if (flag_q[0] && mask_q[`TCS_MASK_MEAS]) begin
            irq_d = 1'b1;
        end
    end

    // level interrupt output
    // registered, so it trails the flag by one cycle
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign irq_o = irq_q;

endmodule // tcs_counter_status

/* File: bench/tcs_sva.sv */
`include "tcs_defs.vh"
module tcs_sva (
    input wire core_clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [11:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire meas_done_i,
    input wire counter_enable_o,
    input wire irq_o
);
    // ------------------------------------------
    // mask shadow, updated at the ack edge
    // ------------------------------------------
    reg [3:0] mask_q;
    wire [9:0] idx = wb_adr_i[11:2];
    wire rd_cnt = wb_ack_o && !wb_we_i &&
        (idx == `TCS_IDX_CNT_LO || idx == `TCS_IDX_CNT_HI);
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i)
            mask_q <= 4'h0;
        else if (wb_ack_o && wb_we_i && wb_sel_i[0] && idx == `TCS_IDX_STAT)
            mask_q <= wb_dat_i[3:0];
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
        wb_ack_o) else $error("request not acked next cycle");
    dat_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    upper_zero_a: assert property (
        wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
    meas_irq_a: assert property (
        meas_done_i && mask_q[0] && !wb_cyc_i && !wb_ack_o ##1 !wb_cyc_i
        |=> irq_o) else $error("measurement done raised no irq");
    irq_off_a: assert property ($past(mask_q) == 4'h0 |-> !irq_o)
        else $error("irq with all masks clear");
    count_clear_a: assert property (
        rd_cnt && !counter_enable_o && !$past(counter_enable_o) &&
        !$past(counter_enable_o, 2) && !$past(counter_enable_o, 3)
        |-> wb_dat_o == 32'h0) else $error("count not zero when disabled");
    mask_read_a: assert property (
        wb_ack_o && !wb_we_i && idx == `TCS_IDX_STAT
        |-> wb_dat_o[3:0] == mask_q) else $error("mask readback wrong");
    cover property (meas_done_i && mask_q[0]);
    cover property ($rose(irq_o));
    cover property (rd_cnt && counter_enable_o);
endmodule // tcs_sva

bind tcs_counter_status tcs_sva i_tcs_sva (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .meas_done_i(meas_done_i), .counter_enable_o(counter_enable_o),
    .irq_o(irq_o));

/* File: bench/testbench.sv */
`include "tcs_defs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic cyc = 1'h0, stb = 1'h0, we = 1'h0, run = 1'h0;
    logic lt = 1'h0, ot = 1'h0, md = 1'h0;
    logic [11:0] adr = 12'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rd;
    logic [6:0] src = 7'h0;
    wire [31:0] dat_o;
    wire ack, irq_o, en_o;
    int num_errors = 0, checked = 0, flg_m = 0, n;

    tcs_counter_status i_tcs_counter_status (.core_clk_i(core_clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .run_i(run), .low_tick_i(lt), .osc_tick_i(ot),
        .meas_done_i(md), .cmp0_i(src[0]), .low_speed_osc_i(src[1]),
        .cmp1_i(src[2]), .relaxation_osc_tc_i(src[3]),
        .interval_timer_i(src[4]), .relaxation_osc_irq_i(src[5]),
        .analog_bus_i(src[6]), .counter_enable_o(en_o), .irq_o(irq_o));

    initial forever #4 core_clk_i = ~core_clk_i;

    // ------------------------------------------
    // bus and compare helpers
    // ------------------------------------------
    task automatic wt(input int c);
        repeat (c) @(posedge core_clk_i);
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [9:0] i,
        input logic [7:0] d, input logic [3:0] s = 4'hF);
        @(posedge core_clk_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= {i, 2'h0};
        wdat <= {24'h0, d};
        sel <= s;
        do begin
            @(posedge core_clk_i);
        end while (ack !== 1'h1);
        rd = dat_o;
        chk("ack", ack, 32'h1);
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask
    task automatic rdc(input logic [9:0] i, input int e, input string nm);
        bus(1'h0, i, 8'h0);
        chk(nm, rd, e & 255);
    endtask
    // status write: zero clears a flag, mask takes the value
    task automatic wst(input logic [7:0] v);
        bus(1'h1, `TCS_IDX_STAT, v);
        flg_m = flg_m & v & 8'hF0 | v & 8'h0F;
        wt(2);
        chk("irq", irq_o, |(flg_m[7:4] & flg_m[3:0]));
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge core_clk_i);
        num_errors++;
        tally_and_finish;
    end

    // ------------------------------------------
    // tests
    // ------------------------------------------
    initial begin
        n = $urandom(32'h9D78);
        repeat (8) @(posedge core_clk_i);
        rst_i <= 1'h0;
        rdc(`TCS_IDX_CNT_LO, 0, "cnt_lo");
        rdc(`TCS_IDX_CNT_HI, 0, "cnt_hi");
        rdc(`TCS_IDX_STAT, 0, "stat");
        rdc(10'h0FF, 0, "unmapped");
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            src <= 7'h0;
            bus(1'h1, `TCS_IDX_CTRL, c[7:0]);
            wt(2);
            wst(8'h00);
            src <= (c < 7) ? 7'h01 << c : 7'h7F;
            wt(3);
            if (c < 7)
                flg_m |= 8'h80;
            rdc(`TCS_IDX_STAT, flg_m, "edge flag");
        end
        src <= 7'h0;
        wst(8'h00);
        $display("test edge sources done");
        bus(1'h1, `TCS_IDX_CTRL, 8'h10);
        n = $urandom_range(250, 1);
        run <= 1'h1;
        lt <= 1'h1;
        wt(n);
        lt <= 1'h0;
        run <= 1'h0;
        chk("enable", en_o, 32'h1);
        rdc(`TCS_IDX_CNT_LO, n, "cnt_lo");
        bus(1'h1, `TCS_IDX_CNT_LO, 8'h5A);
        rdc(`TCS_IDX_CNT_LO, n, "cnt_lo ro");
        run <= 1'h1;
        lt <= 1'h1;
        wt(256 - n);
        lt <= 1'h0;
        run <= 1'h0;
        flg_m |= 8'h40;
        rdc(`TCS_IDX_CNT_LO, 0, "cnt_lo wrap");
        rdc(`TCS_IDX_CNT_HI, 1, "cnt_hi");
        rdc(`TCS_IDX_STAT, flg_m, "low carry");
        bus(1'h1, `TCS_IDX_CTRL, 8'h00);
        wt(2);
        rdc(`TCS_IDX_CNT_HI, 0, "cnt_hi off");
        bus(1'h1, `TCS_IDX_CTRL, 8'h30);
        run <= 1'h1;
        ot <= 1'h1;
        wt(256);
        ot <= 1'h0;
        run <= 1'h0;
        flg_m |= 8'h20;
        rdc(`TCS_IDX_CNT_HI, 0, "cnt_hi wrap");
        rdc(`TCS_IDX_STAT, flg_m, "high carry");
        md <= 1'h1;
        wt(1);
        md <= 1'h0;
        src <= 7'h01;
        wt(3);
        flg_m |= 8'h90;
        rdc(`TCS_IDX_STAT, flg_m, "meas");
        $display("test counts done");
        bus(1'h1, `TCS_IDX_STAT, 8'h00, 4'h0);
        rdc(`TCS_IDX_STAT, 8'hF0, "sel ignored");
        // counter off before the masks change
        bus(1'h1, `TCS_IDX_CTRL, 8'h00);
        for (int k = 7; k > 3; k--) begin
            wst(8'hF0 | (8'h01 << (k - 4)));
            wst(~(8'h01 << k) & 8'hF0 | (8'h01 << (k - 4)));
        end
        md <= 1'h1;
        wt(1);
        md <= 1'h0;
        wt(3);
        chk("irq meas", irq_o, 32'h1);
        $display("test mask done");
        // inverted input: a falling pin is a rising event
        bus(1'h1, `TCS_IDX_CTRL, 8'h08);
        wst(8'h00);
        chk("enable off", en_o, 32'h0);
        src <= 7'h00;
        wt(3);
        rdc(`TCS_IDX_STAT, 8'h80, "inverted edge");
        rdc(`TCS_IDX_CTRL, 8'h88, "ctrl level");
        $display("test invert done");
        tally_and_finish;
    end
endmodule // testbench
